// ---- verilog/iwdt_consts.svh ----
// Register offsets, field positions, reset values and count constants of the watchdog
`ifndef IWDT_CONSTS_SVH
`define IWDT_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define IWDT_OFS_CFG        8'h00
`define IWDT_OFS_CTRL       8'h04
`define IWDT_OFS_REFRESH    8'h08
`define IWDT_OFS_STATUS     8'h0C
`define IWDT_OFS_IMASK      8'h10

// ==========================================================
// Configuration field positions
`define IWDT_CFG_TOUT_LSB   0
`define IWDT_CFG_DIV_LSB    4
`define IWDT_CFG_WEND_LSB   8
`define IWDT_CFG_WSTART_LSB 12
`define IWDT_CFG_WMASK      14'h33F3

// Control and status field positions
`define IWDT_CTRL_START_BIT 0
`define IWDT_CTRL_ERRDIS_BIT 7
`define IWDT_STAT_RERR_BIT  15
`define IWDT_STAT_UFL_BIT   14
`define IWDT_REFRESH_KEY    8'hA5

// ==========================================================
// Reset values: 1024 cycles, divide by 64, window 100% to 0%, error output enabled
`define IWDT_CFG_RST        14'h3340
`define IWDT_IMASK_RST      2'h0

// ==========================================================
// Counter load values (timeout cycles minus one)
`define IWDT_LOAD_1024      14'h03FF
`define IWDT_LOAD_4096      14'h0FFF
`define IWDT_LOAD_8192      14'h1FFF
`define IWDT_LOAD_16384     14'h3FFF

// Division codes and prescaler terminal counts (ratio minus one)
`define IWDT_DIV_CODE_1     4'h0
`define IWDT_DIV_CODE_16    4'h2
`define IWDT_DIV_CODE_32    4'h3
`define IWDT_DIV_CODE_64    4'h4
`define IWDT_DIV_CODE_128   4'hF
`define IWDT_DIV_CODE_256   4'h5
`define IWDT_DIV_TC_1       8'h00
`define IWDT_DIV_TC_16      8'h0F
`define IWDT_DIV_TC_32      8'h1F
`define IWDT_DIV_TC_64      8'h3F
`define IWDT_DIV_TC_128     8'h7F
`define IWDT_DIV_TC_256     8'hFF

`endif

// ---- verilog/iwdt_pkg.sv ----
// Types shared by the watchdog modules
package iwdt_pkg;

   // ==========================================================
   // Watchdog counting states
   typedef enum logic [1:0] {
      WD_IDLE,
      WD_RUN,
      WD_UFL
   } iwdt_state_t;

   // ==========================================================
   // State of the count clock divider
   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic       prev;
      logic [7:0] pre;
      logic       tick;
   } iwdt_tick_st_t;

   // ==========================================================
   // State of the watchdog core
   typedef struct packed {
      iwdt_state_t st;
      logic [13:0] cnt;
      logic [13:0] cfg;
      logic        start;
      logic        err_dis;
      logic        rerr;
      logic        ufl;
      logic [1:0]  imask;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        irq;
      logic        err;
   } iwdt_core_st_t;

endpackage

// ---- verilog/iwdt_tick_if.sv ----
// Divider selection and divided tick between the core and the count clock divider
interface iwdt_tick_if;
   logic [3:0] div_sel;
   logic       tick;

   modport ctl (output div_sel, input tick);
   modport gen (input div_sel, output tick);
endinterface

// ---- verilog/iwdt_tick.sv ----
// Count clock synchroniser and selectable prescaler
`include "iwdt_consts.svh"

module iwdt_tick (
   input  wire logic  clk_i,
   input  wire logic  reset_i,
   input  wire logic  cnt_clk_i,
   iwdt_tick_if.gen   tk
);

   iwdt_pkg::iwdt_tick_st_t s;
   iwdt_pkg::iwdt_tick_st_t n;
   logic                    edge_det;
   logic [7:0]              tc;

   // ==========================================================
   // Terminal count for the selected division ratio
   always_comb begin
      case (tk.div_sel)
         `IWDT_DIV_CODE_1:   tc = `IWDT_DIV_TC_1;
         `IWDT_DIV_CODE_16:  tc = `IWDT_DIV_TC_16;
         `IWDT_DIV_CODE_32:  tc = `IWDT_DIV_TC_32;
         `IWDT_DIV_CODE_128: tc = `IWDT_DIV_TC_128;
         `IWDT_DIV_CODE_256: tc = `IWDT_DIV_TC_256;
         default:            tc = `IWDT_DIV_TC_64; // Unknown codes fall back to /64
      endcase
   end

   assign edge_det = s.sync2 & ~s.prev;

   // ==========================================================
   // Two-stage synchroniser, edge detect and prescaler
   always_comb begin
      n       = s;
      n.sync1 = cnt_clk_i;
      n.sync2 = s.sync1;
      n.prev  = s.sync2;
      n.tick  = 1'b0;
      if (edge_det) begin
         if (s.pre >= tc) begin // R1
            n.pre  = 8'h00;
            n.tick = 1'b1;
         end else begin
            n.pre = 8'(s.pre + 8'h01);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         s <= '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0, pre: 8'h00, tick: 1'b0};
      end else begin
         s <= n;
      end
   end

   assign tk.tick = s.tick;

   // ==========================================================
   // Checks
   property p_tick_at_tc;
      @(posedge clk_i) disable iff (reset_i)
      s.tick |-> $past(edge_det && s.pre >= tc);
   endproperty
   a_tick_at_tc: assert property (p_tick_at_tc) else $error("tick without terminal count"); // R1

   property p_tick_gap;
      @(posedge clk_i) disable iff (reset_i)
      (s.tick && tk.div_sel == `IWDT_DIV_CODE_64) |=> !s.tick [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("divided ticks too close"); // R1

   c_tick: cover property (@(posedge clk_i) disable iff (reset_i) s.tick);

endmodule

// ---- verilog/iwdt_core.sv ----
// Independent watchdog with APB registers, refresh window and error output
//
// Our own choices: register access over APB and the placing of the registers.
`include "iwdt_consts.svh"

// Function
// R1 - The counter advances on the watchdog count clock divided by the selected ratio, by 64 after reset.
// R2 - The timeout is a selectable number of divided cycles, 1024 after reset.
// R3 - An underflow or a wrong refresh raises the error output toward the error control module.
// R4 - Software refreshes the counter at intervals shorter than the timeout.
// R5 - Without refreshes the counter runs on to underflow and signals the error with no software action.
// R6 - Status bit 15 holds the refresh-error flag.
// R7 - Status bit 14 holds the underflow flag.
// R8 - Status bits 13 to 0 hold the current counter value.
// R9 - The counter counts down from the timeout value and a refresh reloads the full period.
// R10 - With window start 100% and window end 0% a refresh is accepted at any count.
module iwdt_core (
   input  wire logic        CLK_I,
   input  wire logic        RESET_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        IWDTCLK_I,
   output logic             IRQ_O,
   output logic             ERR_O
);

   iwdt_pkg::iwdt_core_st_t s;
   iwdt_pkg::iwdt_core_st_t n;
   logic                    access;
   logic                    wr;
   logic                    wr_cfg;
   logic                    wr_ctrl;
   logic                    wr_ref;
   logic                    wr_stat;
   logic                    wr_mask;
   logic                    key_ok;
   logic                    in_win;
   logic                    ref_ok;
   logic [13:0]             load;
   logic [13:0]             start_thr;
   logic [13:0]             end_thr;
   logic [1:0]              wstart;
   logic [1:0]              wend;

   iwdt_tick_if tk ();

   // ==========================================================
   // Count clock divider
   iwdt_tick u_tick (
      .clk_i     (CLK_I),
      .reset_i   (RESET_I),
      .cnt_clk_i (IWDTCLK_I),
      .tk        (tk)
   );

   assign tk.div_sel = s.cfg[`IWDT_CFG_DIV_LSB +: 4];

   // ==========================================================
   // Bus decode; writes take effect at the completing edge
   assign access  = PSEL_I & PENABLE_I;
   assign wr      = access & s.pready & PWRITE_I;
   assign wr_cfg  = wr & (PADDR_I == `IWDT_OFS_CFG);
   assign wr_ctrl = wr & (PADDR_I == `IWDT_OFS_CTRL);
   assign wr_ref  = wr & (PADDR_I == `IWDT_OFS_REFRESH);
   assign wr_stat = wr & (PADDR_I == `IWDT_OFS_STATUS);
   assign wr_mask = wr & (PADDR_I == `IWDT_OFS_IMASK);

   // ==========================================================
   // Timeout load value for the selected period
   always_comb begin
      unique case (s.cfg[`IWDT_CFG_TOUT_LSB +: 2])
         2'h0: load = `IWDT_LOAD_1024; // R2
         2'h1: load = `IWDT_LOAD_4096;
         2'h2: load = `IWDT_LOAD_8192;
         2'h3: load = `IWDT_LOAD_16384;
      endcase
   end

   assign wstart = s.cfg[`IWDT_CFG_WSTART_LSB +: 2];
   assign wend   = s.cfg[`IWDT_CFG_WEND_LSB +: 2];

   // Window thresholds as fractions of the period
   always_comb begin
      unique case (wstart)
         2'h0: start_thr = load >> 2;
         2'h1: start_thr = load >> 1;
         2'h2: start_thr = 14'(load - (load >> 2));
         2'h3: start_thr = load; // R10
      endcase
      unique case (wend)
         2'h0: end_thr = 14'(load - (load >> 2));
         2'h1: end_thr = load >> 1;
         2'h2: end_thr = load >> 2;
         2'h3: end_thr = 14'h0000; // R10
      endcase
   end

   // Refresh window; while running, outside it a keyed refresh only sets the error flag
   assign in_win = (s.cnt <= start_thr) && (s.cnt >= end_thr); // R10
   assign key_ok = (PWDATA_I[7:0] == `IWDT_REFRESH_KEY);
   // After underflow any keyed refresh restarts, so software can recover without a reset
   assign ref_ok = key_ok & (in_win | (s.st == iwdt_pkg::WD_UFL));

   // ==========================================================
   // Next state: registers, counter, flags and bus answer
   always_comb begin
      n         = s;
      n.pready  = access & ~s.pready;
      n.pslverr = 1'b0;
      if (access & ~s.pready) begin
         n.prdata = 32'h0000_0000;
         unique case (PADDR_I)
            `IWDT_OFS_CFG:     n.prdata = {18'h0_0000, s.cfg};
            `IWDT_OFS_CTRL:    n.prdata = {24'h00_0000, s.err_dis, 6'h00, s.start};
            `IWDT_OFS_REFRESH: n.prdata = 32'h0000_0000;
            `IWDT_OFS_STATUS:  n.prdata = {16'h0000, s.rerr, s.ufl, s.cnt}; // R6 R7 R8
            `IWDT_OFS_IMASK:   n.prdata = {16'h0000, s.imask, 14'h0000};
            default:           n.pslverr = 1'b1;
         endcase
      end
      // Configuration is locked once counting has started
      if (wr_cfg && !s.start) begin
         n.cfg = PWDATA_I[13:0] & `IWDT_CFG_WMASK;
      end
      if (wr_ctrl && !s.start) begin
         n.err_dis = PWDATA_I[`IWDT_CTRL_ERRDIS_BIT];
         n.start   = PWDATA_I[`IWDT_CTRL_START_BIT];
      end
      if (wr_mask) begin
         n.imask = PWDATA_I[`IWDT_STAT_UFL_BIT +: 2];
      end
      // Write one to clear; events below set again and win
      if (wr_stat) begin
         if (PWDATA_I[`IWDT_STAT_RERR_BIT]) begin
            n.rerr = 1'b0;
         end
         if (PWDATA_I[`IWDT_STAT_UFL_BIT]) begin
            n.ufl = 1'b0;
         end
      end
      // Counter loads on start, reloads on a good refresh and steps down on each divided tick
      unique case (s.st)
         iwdt_pkg::WD_IDLE: begin
            if (wr_ctrl && PWDATA_I[`IWDT_CTRL_START_BIT]) begin
               n.st  = iwdt_pkg::WD_RUN;
               n.cnt = load; // R2
            end
         end
         iwdt_pkg::WD_RUN: begin
            if (wr_ref) begin
               if (ref_ok) begin
                  n.cnt = load; // R9
               end else begin
                  n.rerr = 1'b1; // R3
               end
            end else if (tk.tick) begin
               if (s.cnt == 14'h0000) begin
                  n.ufl = 1'b1; // R5
                  n.st  = iwdt_pkg::WD_UFL;
               end else begin
                  n.cnt = 14'(s.cnt - 14'h0001); // R9
               end
            end
         end
         iwdt_pkg::WD_UFL: begin
            if (wr_ref) begin
               if (ref_ok) begin
                  n.cnt = load; // R9
                  n.st  = iwdt_pkg::WD_RUN;
               end else begin
                  n.rerr = 1'b1; // R3
               end
            end
         end
      endcase
      // Interrupt and error output follow the next flags, so they rise together with them
      n.irq = (n.rerr & n.imask[1]) | (n.ufl & n.imask[0]);
      n.err = (n.rerr | n.ufl) & ~n.err_dis; // R3
   end

   // ==========================================================
   // State register
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         s <= '{st: iwdt_pkg::WD_IDLE, cnt: 14'h0000, cfg: `IWDT_CFG_RST, start: 1'b0,
                err_dis: 1'b0, rerr: 1'b0, ufl: 1'b0, imask: `IWDT_IMASK_RST,
                pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, irq: 1'b0, err: 1'b0};
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register
   assign PRDATA_O  = s.prdata;
   assign PREADY_O  = s.pready;
   assign PSLVERR_O = s.pslverr;
   assign IRQ_O     = s.irq;
   assign ERR_O     = s.err;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RESET_I);

   property p_start_load;
      (wr_ctrl && PWDATA_I[`IWDT_CTRL_START_BIT] && s.st == iwdt_pkg::WD_IDLE)
         |=> (s.st == iwdt_pkg::WD_RUN && s.cnt == $past(load));
   endproperty
   a_start_load: assert property (p_start_load) else $error("start did not load period"); // R2

   property p_err_follows;
      ($rose(s.ufl) || $rose(s.rerr)) && !s.err_dis |-> ERR_O ##1 (ERR_O || !(s.ufl || s.rerr));
   endproperty
   a_err_follows: assert property (p_err_follows) else $error("error output not raised"); // R3

   property p_underflow;
      (s.st == iwdt_pkg::WD_RUN && tk.tick && s.cnt == 14'h0000 && !wr_ref)
         |=> s.ufl && s.st == iwdt_pkg::WD_UFL && (ERR_O || s.err_dis);
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow not flagged"); // R5

   property p_stat_rerr;
      (access && !s.pready && !PWRITE_I && PADDR_I == `IWDT_OFS_STATUS)
         |=> PREADY_O && PRDATA_O[15] == $past(s.rerr);
   endproperty
   a_stat_rerr: assert property (p_stat_rerr) else $error("status bit 15 wrong"); // R6

   property p_stat_ufl;
      (access && !s.pready && !PWRITE_I && PADDR_I == `IWDT_OFS_STATUS)
         |=> PRDATA_O[14] == $past(s.ufl);
   endproperty
   a_stat_ufl: assert property (p_stat_ufl) else $error("status bit 14 wrong"); // R7

   property p_stat_cnt;
      (access && !s.pready && !PWRITE_I && PADDR_I == `IWDT_OFS_STATUS)
         |=> PRDATA_O[13:0] == $past(s.cnt) && PRDATA_O[31:16] == 16'h0000;
   endproperty
   a_stat_cnt: assert property (p_stat_cnt) else $error("status count wrong"); // R8

   property p_decrement;
      (s.st == iwdt_pkg::WD_RUN && tk.tick && s.cnt != 14'h0000 && !wr_ref)
         |=> s.cnt == 14'($past(s.cnt) - 14'h0001);
   endproperty
   a_decrement: assert property (p_decrement) else $error("counter did not step down"); // R9

   property p_reload;
      (wr_ref && ref_ok && s.st != iwdt_pkg::WD_IDLE) |=> s.cnt == $past(load) && s.st == iwdt_pkg::WD_RUN;
   endproperty
   a_reload: assert property (p_reload) else $error("refresh did not reload"); // R9

   property p_full_window;
      (wr_ref && key_ok && wstart == 2'h3 && wend == 2'h3 && s.st == iwdt_pkg::WD_RUN)
         |=> s.rerr == $past(s.rerr);
   endproperty
   a_full_window: assert property (p_full_window) else $error("refresh refused in full window"); // R10

   // ==========================================================
   // Refresh errors, sticky flags and locked settings
   property p_wrong_key;
      (wr_ref && !key_ok && s.st != iwdt_pkg::WD_IDLE) |=> s.rerr;
   endproperty
   a_wrong_key: assert property (p_wrong_key) else $error("wrong key not flagged"); // R3

   property p_early_refresh;
      (wr_ref && key_ok && !in_win && s.st == iwdt_pkg::WD_RUN)
         |=> s.rerr && s.cnt == $past(s.cnt);
   endproperty
   a_early_refresh: assert property (p_early_refresh) else $error("refresh outside window accepted"); // R3

   property p_cfg_lock;
      (wr_cfg && s.start) |=> $stable(s.cfg);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("settings changed while counting"); // R2

   property p_ufl_hold;
      s.st == iwdt_pkg::WD_UFL |-> s.cnt == 14'h0000;
   endproperty
   a_ufl_hold: assert property (p_ufl_hold) else $error("counter moved after underflow"); // R5

   property p_rerr_sticky;
      (s.rerr && !wr_stat) |=> s.rerr;
   endproperty
   a_rerr_sticky: assert property (p_rerr_sticky) else $error("refresh error flag lost"); // R6

   property p_ufl_sticky;
      (s.ufl && !wr_stat) |=> s.ufl;
   endproperty
   a_ufl_sticky: assert property (p_ufl_sticky) else $error("underflow flag lost"); // R7

   property p_idle_refresh;
      (wr_ref && s.st == iwdt_pkg::WD_IDLE) |=> s.st == iwdt_pkg::WD_IDLE && s.rerr == $past(s.rerr);
   endproperty
   a_idle_refresh: assert property (p_idle_refresh) else $error("refresh acted before start"); // R9

   c_underflow: cover property (s.st == iwdt_pkg::WD_RUN ##1 s.st == iwdt_pkg::WD_UFL);
   c_rerr:      cover property ($rose(s.rerr));
   c_refresh:   cover property (wr_ref && ref_ok && s.st == iwdt_pkg::WD_RUN);
   c_irq:       cover property ($rose(IRQ_O));

endmodule

// ---- test/testbench.sv ----
// Self-checking testbench of the independent watchdog core
`include "iwdt_consts.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wclk;
   logic        wclk_ph;
   logic        irq;
   logic        err;
   logic [31:0] rd;
   logic        serr;
   logic [31:0] c0;
   logic [31:0] key;
   int          err_count;
   int          tests_run;
   int          cyc;
   int          t0;
   int          n;
   int          seed;

   iwdt_core u_iwdt_core (
      .CLK_I     (clk),
      .RESET_I   (rst),
      .PSEL_I    (psel),
      .PENABLE_I (penable),
      .PWRITE_I  (pwrite),
      .PADDR_I   (paddr),
      .PWDATA_I  (pwdata),
      .PRDATA_O  (prdata),
      .PREADY_O  (pready),
      .PSLVERR_O (pslverr),
      .IWDTCLK_I (wclk),
      .IRQ_O     (irq),
      .ERR_O     (err)
   );

   // ==========================================================
   // Clocks and timeout
   // System clock, 4 ns period
   always #2 clk = ~clk;

   // Count clock with two cycles high and two low, plus a hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      wclk_ph <= ~wclk_ph;
      if (wclk_ph) begin
         wclk <= ~wclk;
      end
      if (cyc == 40000) begin
         err_count++;
         close_out();
      end
   end

   // ==========================================================
   // Helpers
   function automatic logic [31:0] f_cfg(input logic [1:0] t, input logic [3:0] dv, input logic [1:0] we,
                                         input logic [1:0] ws);
      return {18'h0, ws, 2'h0, we, dv, 2'h0, t};
   endfunction

   function automatic logic [31:0] f_stat(input logic r, input logic u, input logic [13:0] c);
      return {16'h0, r, u, c};
   endfunction

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Synchronous reset held for six cycles
   task automatic do_reset;
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   // Prints the counts and the verdict, then stops
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wclk = 1'b0;
      wclk_ph = 1'b0;
      cyc = 0;
      err_count = 0;
      tests_run = 0;
      seed = 32'he3c05eb8;
      do_reset();
      apb(1'b0, `IWDT_OFS_CFG, 32'h0);
      chk(rd, f_cfg(2'h0, 4'h4, 2'h3, 2'h3));
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd, f_stat(1'b0, 1'b0, 14'h0));
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      chk(32'(serr), 32'h1);
      $display("Reset values test done");
      // Divide by one, 1024 cycles, full window, both events unmasked
      apb(1'b1, `IWDT_OFS_CFG, f_cfg(2'h0, 4'h0, 2'h3, 2'h3));
      apb(1'b1, `IWDT_OFS_IMASK, 32'h0000C000);
      apb(1'b1, `IWDT_OFS_CTRL, 32'h1);
      t0 = cyc;
      apb(1'b1, `IWDT_OFS_CFG, 32'h0);
      apb(1'b0, `IWDT_OFS_CFG, 32'h0);
      chk(rd, f_cfg(2'h0, 4'h0, 2'h3, 2'h3));
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      c0 = rd;
      chk(c0[15:4], 12'h03F);
      repeat (36) @(posedge clk);
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(c0 - rd, 32'd10);
      while (err !== 1'b1 && (cyc - t0) < 6000) @(posedge clk);
      chk(32'((cyc - t0 >= 4080) && (cyc - t0 <= 4110)), 32'h1);
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd, f_stat(1'b0, 1'b1, 14'h0));
      chk(err, 1'b1);
      chk(irq, 1'b1);
      $display("Underflow test done");
      // Refresh after underflow restarts, then clear the flag
      apb(1'b1, `IWDT_OFS_REFRESH, {24'h0, `IWDT_REFRESH_KEY});
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd[15:4], 12'h43F);
      apb(1'b1, `IWDT_OFS_STATUS, 32'h00004000);
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd[15:14], 2'b00);
      chk({err, irq}, 2'b00);
      // Refreshes late in the period and at random moments
      for (int i = 0; i < 5; i++) begin
         n = (i == 0) ? 4060 : {$random(seed)} % 3000;
         repeat (n) @(posedge clk);
         apb(1'b1, `IWDT_OFS_REFRESH, {24'h0, `IWDT_REFRESH_KEY});
         apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
         chk(rd[15:4], 12'h03F);
         chk(err, 1'b0);
      end
      $display("Refresh test done");
      // Wrong refresh key raises the error, masking and clearing
      key = $random(seed);
      key[7:0] = (key[7:0] == `IWDT_REFRESH_KEY) ? 8'h5A : key[7:0];
      apb(1'b1, `IWDT_OFS_REFRESH, key);
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd[15:14], 2'b10);
      chk({err, irq}, 2'b11);
      apb(1'b1, `IWDT_OFS_IMASK, 32'h00004000);
      repeat (2) @(posedge clk);
      chk({err, irq}, 2'b10);
      apb(1'b1, `IWDT_OFS_STATUS, 32'h00008000);
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd[15:14], 2'b00);
      chk(err, 1'b0);
      $display("Refresh error test done");
      // Default divide by 64 with the error output disabled
      do_reset();
      apb(1'b1, `IWDT_OFS_CTRL, 32'h81);
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      c0 = rd;
      repeat (764) @(posedge clk);
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(c0 - rd, 32'd3);
      apb(1'b1, `IWDT_OFS_REFRESH, 32'h0);
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd[15:14], 2'b10);
      chk(err, 1'b0);
      $display("Divider and disable test done");
      // 4096 cycles, window 75% to 50%: early refresh is an error, one inside the window reloads
      do_reset();
      apb(1'b1, `IWDT_OFS_CFG, f_cfg(2'h1, 4'h0, 2'h1, 2'h2));
      apb(1'b1, `IWDT_OFS_CTRL, 32'h1);
      apb(1'b1, `IWDT_OFS_REFRESH, {24'h0, `IWDT_REFRESH_KEY});
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd[15:4], 12'h8FF);
      chk({err, irq}, 2'b10);
      apb(1'b1, `IWDT_OFS_STATUS, 32'h00008000);
      repeat (5000) @(posedge clk);
      apb(1'b1, `IWDT_OFS_REFRESH, {24'h0, `IWDT_REFRESH_KEY});
      apb(1'b0, `IWDT_OFS_STATUS, 32'h0);
      chk(rd[15:4], 12'h0FF);
      chk(err, 1'b0);
      $display("Window test done");
      close_out();
   end
endmodule
